// *** pkg/adc_seq_pkg.sv ***
// How it works
// - Start write: sample during next ADC clock
// - Convert over following six ADC clocks
// - Result registers update on next ADC clock
// - Four triggers: two bits, pin, event
// - At least three clocks trigger to sample
// - At least three clocks conversion end to FIFO
`default_nettype none

package adc_seq_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int RES_W      = 10;
	localparam int PRESCALE_W = 4;
	localparam int CNT_W      = 3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS     = 100;
	localparam int ADC_MIN_PERIOD_US = 1;
	// Least period rounds up to whole system clocks
	localparam int ADC_MIN_PERIOD_CYC =
		(ADC_MIN_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [PRESCALE_W-1:0] PRESCALE_MIN =
		PRESCALE_W'(ADC_MIN_PERIOD_CYC - 1);
	localparam logic [CNT_W-1:0] SOC_SETUP_CYC = 3'h3;
	localparam logic [CNT_W-1:0] EOC_FIFO_CYC  = 3'h3;
	localparam logic [CNT_W-1:0] CONV_TICKS    = 3'h6;
	localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 4'hf;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_SAMPLE,
		ST_CONVERT,
		ST_RESULT,
		ST_LOAD
	} seq_state_t;

endpackage
`default_nettype wire

// *** src/adc_clock_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_clock_prescaler (
	input  wire logic                              clk_i,
	input  wire logic                              sys_rst_i,
	input  wire logic [adc_seq_pkg::PRESCALE_W-1:0] prescale_i,
	output logic                                   tick_o
);
	import adc_seq_pkg::*;

	logic [PRESCALE_W-1:0] div_reg;
	logic [PRESCALE_W-1:0] div_next;
	logic                  tick_reg;
	logic                  tick_next;

	// ----------------------------------------
	// Divider: one tick every prescale_i+1 clocks
	// ----------------------------------------
	always_comb begin
		tick_next = 1'b0;
		div_next  = div_reg + PRESCALE_W'(1);
		if (div_reg >= prescale_i) begin
			div_next  = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			div_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_o = tick_reg;

endmodule // adc_clock_prescaler
`default_nettype wire

// *** src/adc_conversion_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer (
	input  wire logic                              clk_i,
	input  wire logic                              sys_rst_i,
	input  wire logic                              immediate_start_bit_i,
	input  wire logic                              conversion_start_bit_i,
	input  wire logic                              conversion_start_request_i,
	input  wire logic                              event_manager_start_i,
	input  wire logic [adc_seq_pkg::PRESCALE_W-1:0] prescale_i,
	input  wire logic [adc_seq_pkg::RES_W-1:0]      conv_data_a_i,
	input  wire logic [adc_seq_pkg::RES_W-1:0]      conv_data_b_i,
	output logic                                   sample_hold_o,
	output logic                                   converting_o,
	output logic                                   busy_o,
	output logic [adc_seq_pkg::RES_W-1:0]           result_a_o,
	output logic [adc_seq_pkg::RES_W-1:0]           result_b_o,
	output logic                                   result_valid_o,
	output logic [adc_seq_pkg::RES_W-1:0]           fifo_data_a_o,
	output logic [adc_seq_pkg::RES_W-1:0]           fifo_data_b_o,
	output logic                                   fifo_load_o,
	output logic                                   start_ignored_o,
	output logic                                   prescale_fast_o
);
	import adc_seq_pkg::*;

	// ----------------------------------------
	// Trigger detection
	// ----------------------------------------
	logic       pin_meta_reg;
	logic       pin_sync_reg;
	logic       pin_last_reg;
	logic       evt_last_reg;
	logic       adc_tick;
	logic       trig;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_last_reg <= 1'b0;
			evt_last_reg <= 1'b0;
		end else begin
			pin_meta_reg <= conversion_start_request_i;
			pin_sync_reg <= pin_meta_reg;
			pin_last_reg <= pin_sync_reg;
			evt_last_reg <= event_manager_start_i;
		end
	end

	// Pin and event start on their rising edge; a held level starts only once
	assign trig = immediate_start_bit_i | conversion_start_bit_i
		| (pin_sync_reg & ~pin_last_reg)
		| (event_manager_start_i & ~evt_last_reg);

	adc_clock_prescaler u_prescaler (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.prescale_i (prescale_i),
		.tick_o     (adc_tick)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	seq_state_t           state_reg;
	seq_state_t           state_next;
	logic [CNT_W-1:0]     cnt_reg;
	logic [CNT_W-1:0]     cnt_next;
	logic [RES_W-1:0]     cap_a_reg;
	logic [RES_W-1:0]     cap_a_next;
	logic [RES_W-1:0]     cap_b_reg;
	logic [RES_W-1:0]     cap_b_next;
	logic [RES_W-1:0]     res_a_reg;
	logic [RES_W-1:0]     res_a_next;
	logic [RES_W-1:0]     res_b_reg;
	logic [RES_W-1:0]     res_b_next;
	logic                 res_valid_reg;
	logic                 res_valid_next;
	logic                 fifo_load_reg;
	logic                 fifo_load_next;
	logic                 ignored_reg;
	logic                 ignored_next;
	logic                 fast_reg;
	logic                 fast_next;

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (v == '1) ? v : v + CNT_W'(1);
	endfunction

	always_comb begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		cap_a_next     = cap_a_reg;
		cap_b_next     = cap_b_reg;
		res_a_next     = res_a_reg;
		res_b_next     = res_b_reg;
		res_valid_next = 1'b0;
		fifo_load_next = 1'b0;
		ignored_next   = trig & (state_reg != ST_IDLE);
		// Flag only; the prescaler still honours whatever software set
		fast_next      = prescale_i < PRESCALE_MIN;
		case (state_reg)
			ST_IDLE: begin
				if (trig) begin
					state_next = ST_SETUP;
					cnt_next   = CNT_W'(1);
				end
			end
			ST_SETUP: begin
				cnt_next = sat_inc(cnt_reg);
				// Sampling waits for the setup count and an ADC clock boundary
				if (cnt_reg >= SOC_SETUP_CYC && adc_tick) begin
					state_next = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (adc_tick) begin
					state_next = ST_CONVERT;
					cnt_next   = '0;
				end
			end
			ST_CONVERT: begin
				if (adc_tick) begin
					cnt_next = cnt_reg + CNT_W'(1);
					if (cnt_next == CONV_TICKS) begin
						state_next = ST_RESULT;
						cap_a_next = conv_data_a_i;
						cap_b_next = conv_data_b_i;
						cnt_next   = CNT_W'(1);
					end
				end
			end
			ST_RESULT: begin
				cnt_next = sat_inc(cnt_reg);
				if (adc_tick) begin
					res_a_next     = cap_a_reg;
					res_b_next     = cap_b_reg;
					res_valid_next = 1'b1;
					state_next     = ST_LOAD;
				end
			end
			ST_LOAD: begin
				cnt_next = sat_inc(cnt_reg);
				// A fast prescaler may reach here before the end-of-conversion gap
				if (cnt_reg >= EOC_FIFO_CYC) begin
					fifo_load_next = 1'b1;
					state_next     = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg     <= ST_IDLE;
			cnt_reg       <= '0;
			cap_a_reg     <= '0;
			cap_b_reg     <= '0;
			res_a_reg     <= '0;
			res_b_reg     <= '0;
			res_valid_reg <= 1'b0;
			fifo_load_reg <= 1'b0;
			ignored_reg   <= 1'b0;
			fast_reg      <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			cap_a_reg     <= cap_a_next;
			cap_b_reg     <= cap_b_next;
			res_a_reg     <= res_a_next;
			res_b_reg     <= res_b_next;
			res_valid_reg <= res_valid_next;
			fifo_load_reg <= fifo_load_next;
			ignored_reg   <= ignored_next;
			fast_reg      <= fast_next;
		end
	end

	assign sample_hold_o   = state_reg == ST_SAMPLE;
	assign converting_o    = state_reg == ST_CONVERT;
	assign busy_o          = state_reg != ST_IDLE;
	assign result_a_o      = res_a_reg;
	assign result_b_o      = res_b_reg;
	assign result_valid_o  = res_valid_reg;
	assign fifo_data_a_o   = res_a_reg;
	assign fifo_data_b_o   = res_b_reg;
	assign fifo_load_o     = fifo_load_reg;
	assign start_ignored_o = ignored_reg;
	assign prescale_fast_o = fast_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [7:0] trig_age;
	logic [3:0] conv_ticks;
	logic [7:0] eoc_age;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			trig_age   <= '0;
			conv_ticks <= '0;
			eoc_age    <= '0;
		end else begin
			trig_age   <= (state_reg == ST_IDLE && trig) ? 8'h00
				: (trig_age == 8'hff ? trig_age : trig_age + 8'h01);
			conv_ticks <= !converting_o ? 4'h0 : conv_ticks + {3'h0, adc_tick};
			eoc_age    <= (converting_o && state_next == ST_RESULT) ? 8'h00
				: (eoc_age == 8'hff ? eoc_age : eoc_age + 8'h01);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_trig_accept: assert property (trig && !busy_o |=> state_reg == ST_SETUP)
		else $error("idle trigger not accepted");
	a_setup_gap: assert property ($rose(sample_hold_o) |-> trig_age >= 8'(SOC_SETUP_CYC))
		else $error("sample began too soon after trigger");
	a_sample_soon: assert property (immediate_start_bit_i && !busy_o |-> ##[4:40] sample_hold_o)
		else $error("no sample after start bit");
	a_sample_one: assert property (sample_hold_o && adc_tick |=> converting_o)
		else $error("sample did not end after one ADC clock");
	// The count lags by one: the sixth tick lands in the last converting cycle
	a_conv_six: assert property ($fell(converting_o)
		|-> $past(conv_ticks) == 4'(CONV_TICKS - 3'h1))
		else $error("conversion not six ADC clocks");
	a_result_tick: assert property ($rose(result_valid_o) |-> $past(adc_tick)
		&& result_a_o == $past(cap_a_reg))
		else $error("result update off ADC clock");
	// Age is zero in the first cycle after conversion end
	a_fifo_gap: assert property (fifo_load_o |-> eoc_age >= 8'(EOC_FIFO_CYC))
		else $error("FIFO load too soon after conversion end");
	a_ignore_busy: assert property (trig && busy_o |=> start_ignored_o
		&& state_reg != ST_SETUP)
		else $error("busy trigger not ignored");

	c_full_run: cover property ($rose(sample_hold_o) ##[1:200] fifo_load_o);
	c_ignored: cover property (start_ignored_o);
	c_pin_start: cover property ($rose(pin_sync_reg) && !busy_o);
	c_event_start: cover property ($rose(event_manager_start_i) && !busy_o);

endmodule // adc_conversion_sequencer
`default_nettype wire

// *** verification/start_source.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Start sources seen by the sequencer
// ----------------------------------------
module start_source (
	input  wire logic       fire_i,
	input  wire logic [1:0] kind_i,
	output logic            imm_o,
	output logic            soc_o,
	output logic            pin_o,
	output logic            ev_o
);
	// Software bits are write pulses; pin and event give one rising edge
	assign imm_o = fire_i && kind_i == 2'h0;
	assign soc_o = fire_i && kind_i == 2'h1;
	assign pin_o = fire_i && kind_i == 2'h2;
	assign ev_o  = fire_i && kind_i == 2'h3;
endmodule // start_source

`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
	import adc_seq_pkg::*;
	logic                  clk_i, sys_rst_i, fire, imm, soc, pin, ev;
	logic                  sh, cv, busy, rv, ld, ign, fast, sh_q, cv_q;
	logic [1:0]            kind;
	logic [PRESCALE_W-1:0] pre;
	logic [RES_W-1:0]      da, db, ra, rb, fa, fb;
	int                    cyc, t_trig, t_sh, t_cv, t_ce, t_rv, t_ld, n_ld, n_ign;
	int                    n_mismatch, comparisons;

	start_source src (.fire_i(fire), .kind_i(kind), .imm_o(imm), .soc_o(soc),
		.pin_o(pin), .ev_o(ev));

	adc_conversion_sequencer DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.immediate_start_bit_i(imm), .conversion_start_bit_i(soc),
		.conversion_start_request_i(pin), .event_manager_start_i(ev),
		.prescale_i(pre), .conv_data_a_i(da), .conv_data_b_i(db),
		.sample_hold_o(sh), .converting_o(cv), .busy_o(busy),
		.result_a_o(ra), .result_b_o(rb), .result_valid_o(rv),
		.fifo_data_a_o(fa), .fifo_data_b_o(fb), .fifo_load_o(ld),
		.start_ignored_o(ign), .prescale_fast_o(fast));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Event time stamps, in clock cycles
	// ----------------------------------------
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 5000) begin
			n_mismatch++;
			$display("BAD %0t timeout", $time);
			finish_test();
		end
		if (imm || soc || pin || ev) t_trig = cyc;
		if (sh && !sh_q) t_sh = cyc;
		if (cv && !cv_q) t_cv = cyc;
		if (!cv && cv_q) t_ce = cyc;
		if (rv) t_rv = cyc;
		if (ld) t_ld = cyc;
		if (ld) n_ld++;
		if (ign) n_ign++;
		sh_q = sh;
		cv_q = cv;
	end

	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic pulse(input logic [1:0] k);
		@(posedge clk_i);
		#1;
		kind = k;
		fire = 1'b1;
		@(posedge clk_i);
		#1;
		fire = 1'b0;
	endtask

	task automatic wait_idle;
		int i;
		i = 0;
		while (busy !== 1'b0 && i < 500) begin
			@(posedge clk_i);
			#1;
			i++;
		end
	endtask

	task automatic set_pre(input logic [PRESCALE_W-1:0] v);
		@(posedge clk_i);
		#1;
		pre = v;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	// Full conversion; p is the ADC clock period in system clocks
	task automatic run_conv(input logic [1:0] k, input logic [RES_W-1:0] v);
		int p, i;
		p = int'(pre) + 1;
		wait_idle();
		da = v;
		db = ~v;
		pulse(k);
		i = 0;
		while (ld !== 1'b1 && i < 500) begin
			@(posedge clk_i);
			#1;
			i++;
		end
		@(posedge clk_i);
		#1;
		check(t_sh - t_trig >= 4 && t_sh - t_trig <= p + 8, "setup delay");
		check(t_cv - t_sh == p, "sample length");
		check(t_ce - t_cv == 6 * p, "convert length");
		check(t_rv - t_ce >= p && t_rv - t_ce <= p + 1, "result timing");
		check(ra === v && rb === ~v, "result value");
		check(t_ld - t_ce >= 3 && fa === v && fb === ~v, "fifo load");
	endtask

	// Starts during a conversion are dropped and flagged
	task automatic t_ignore;
		int n0, m0;
		wait_idle();
		n0 = n_ld;
		m0 = n_ign;
		pulse(2'h0);
		repeat (20) @(posedge clk_i);
		pulse(2'h3);
		pulse(2'h1);
		repeat (200) @(posedge clk_i);
		check(n_ign - m0 == 2 && n_ld - n0 == 1, "ignored starts");
	endtask

	task automatic t_prescale;
		set_pre(4'h8);
		check(fast === 1'b1, "fast flag at 8");
		set_pre(4'h9);
		check(fast === 1'b0, "fast flag at 9");
	endtask

	task automatic finish_test;
		$display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		{fire, kind, da, db, sh_q, cv_q} = '0;
		sys_rst_i = 1'b1;
		pre = PRESCALE_MIN;
		{cyc, t_trig, t_sh, t_cv, t_ce, t_rv, t_ld, n_ld, n_ign} = '0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (10) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		check(busy === 1'b0 && ld === 1'b0 && ra === '0, "reset state");
		for (int k = 0; k < 4; k++) run_conv(2'(k), 10'h2a5 ^ RES_W'(k));
		t_ignore();
		set_pre(4'hf);
		run_conv(2'h1, 10'h3ff);
		set_pre(4'h0);
		run_conv(2'h0, 10'h001);
		t_prescale();
		finish_test();
	end
endmodule // tb

`default_nettype wire
